// ---- serial_host_port.sv ----
`default_nettype none
module serial_host_port
  import serial_host_port_pkg::*;
(
  input  wire logic              mclk_in,
  input  wire logic              rst_n_in,
  input  wire logic              cs_n_in,
  input  wire logic              serial_clock_in,
  input  wire logic              serial_data_in,
  input  wire logic              iface_select_upper_pin_in,
  input  wire logic              iface_select_lower_pin_in,
  output logic                   serial_data_out,
  output logic                   serial_data_oe_n_out,
  output logic [ADDR_W-1:0]      reg_addr_out,
  output logic                   reg_wr_out,
  output logic [DATA_W-1:0]      reg_wr_data_out,
  output logic                   reg_rd_out,
  output logic                   reg_peek_out,
  input  wire logic [DATA_W-1:0] reg_rd_data_in
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    port_state_e       state;
    logic [3:0]        bit_cnt;
    logic [DATA_W-1:0] shift_in;
    logic [DATA_W-1:0] shift_out;
    logic [DATA_W-1:0] rdata;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic              wr;
    logic              rd;
    logic              peek;
    logic              drive;
  } port_s;

  port_s s;
  port_s next_s;
  logic  byte_end;
  logic  live;

  link_if link ();

  pin_sync u_sync (
    .mclk_in                   (mclk_in),
    .rst_n_in                  (rst_n_in),
    .cs_n_in                   (cs_n_in),
    .serial_clock_in           (serial_clock_in),
    .serial_data_in            (serial_data_in),
    .iface_select_upper_pin_in (iface_select_upper_pin_in),
    .iface_select_lower_pin_in (iface_select_lower_pin_in),
    .link                      (link)
  );

  // ****************************************
  // next-state logic
  // ****************************************
  assign live     = link.sel & link.cs_active & ~link.cs_rise & ~link.cs_fall;
  assign byte_end = live & link.sk_fall & (s.bit_cnt == BITS_PER_CYCLE); // [R5]

  always_comb begin
    next_s      = s;
    next_s.wr   = 1'b0;
    next_s.rd   = 1'b0;
    next_s.peek = 1'b0;
    // register file answers in the strobe cycle; take it for the next byte
    if (s.rd || s.peek) begin
      next_s.shift_out = reg_rd_data_in; // [R8] [R12] [R14]
      next_s.rdata     = reg_rd_data_in;
    end
    // side-effect-free read of the register just written
    if (s.wr) begin
      next_s.peek = 1'b1; // [R12] [R13]
    end
    if (!link.sel || !link.cs_active || link.cs_rise) begin
      next_s.state   = ST_CMD; // [R1] [R2]
      next_s.bit_cnt = CNT_ZERO;
      next_s.drive   = 1'b0;
    end else if (link.cs_fall) begin
      next_s.state     = ST_CMD; // [R2]
      next_s.bit_cnt   = CNT_ZERO;
      next_s.shift_out = s.rdata; // [R7]
      next_s.drive     = 1'b1;
    end else if (link.sk_rise) begin
      next_s.shift_in = {s.shift_in[DATA_W-2:0], link.si}; // [R3] [R6]
      if (s.bit_cnt != BITS_PER_CYCLE) begin
        next_s.bit_cnt = s.bit_cnt + CNT_ONE;
      end
    end else if (byte_end) begin
      next_s.bit_cnt = CNT_ZERO; // [R5]
      case (s.state)
        ST_CMD: begin
          next_s.addr      = s.shift_in[ADDR_W-1:0];
          next_s.shift_out = s.rdata; // [R7]
          case (s.shift_in[DATA_W-1 -: 2])
            CMD_READ:  next_s.rd    = 1'b1; // [R8]
            CMD_NOP:   next_s.state = ST_CMD; // [R9]
            CMD_WRITE: next_s.state = ST_WDATA;
            default:   next_s.state = ST_BURST;
          endcase
        end
        ST_WDATA: begin
          next_s.wr      = 1'b1; // [R10]
          next_s.wr_data = s.shift_in;
          next_s.state   = ST_DONE;
        end
        ST_BURST: begin
          next_s.wr      = 1'b1; // [R11]
          next_s.wr_data = s.shift_in;
        end
        default: begin
          // surplus bytes after a standard write are ignored
          next_s.shift_out = s.rdata; // [R10]
        end
      endcase
    end else if (live && link.sk_fall && s.bit_cnt != CNT_ZERO) begin
      next_s.shift_out = {s.shift_out[DATA_W-2:0], 1'b0}; // [R4] [R6]
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{state: ST_CMD, bit_cnt: CNT_ZERO, shift_in: RDATA_RESET,
             shift_out: RDATA_RESET, rdata: RDATA_RESET, addr: ADDR_RESET,
             wr_data: RDATA_RESET, wr: 1'b0, rd: 1'b0, peek: 1'b0, drive: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign serial_data_out      = s.shift_out[DATA_W-1]; // [R6]
  assign serial_data_oe_n_out = ~s.drive;
  assign reg_addr_out         = s.addr;
  assign reg_wr_out           = s.wr;
  assign reg_wr_data_out      = s.wr_data;
  assign reg_rd_out           = s.rd;
  assign reg_peek_out         = s.peek;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);

  a_sel_gate_drive: assert property (!link.sel |=> serial_data_oe_n_out) // [R1]
    else $error("output driven while port not selected");
  a_cs_rise_reset: assert property (link.cs_rise |=>
      s.state == ST_CMD && s.bit_cnt == CNT_ZERO && serial_data_oe_n_out) // [R2]
    else $error("chip select rise did not reset port");
  a_bit_capture: assert property (live && link.sk_rise |=>
      s.shift_in[0] == $past(link.si)) // [R3]
    else $error("input bit not captured on rising clock");
  a_fall_shift: assert property (live && link.sk_fall && s.bit_cnt != BITS_PER_CYCLE
      && s.bit_cnt != CNT_ZERO && !s.rd && !s.peek |=>
      s.shift_out == {$past(s.shift_out[DATA_W-2:0]), 1'b0}) // [R4]
    else $error("output not advanced on falling clock");
  a_byte_count: assert property (reg_wr_out |-> $past(byte_end)) // [R5]
    else $error("write not tied to eighth clock");
  a_read_cmd: assert property (byte_end && s.state == ST_CMD
      && s.shift_in[DATA_W-1 -: 2] == CMD_READ |=>
      reg_rd_out && reg_addr_out == $past(s.shift_in[ADDR_W-1:0])
      ##1 serial_data_out == $past(reg_rd_data_in[DATA_W-1])) // [R7] [R8]
    else $error("read command did not fetch addressed register");
  a_nop_quiet: assert property (byte_end && s.state == ST_CMD
      && s.shift_in[DATA_W-1 -: 2] == CMD_NOP |=>
      !reg_rd_out && !reg_wr_out ##1 !reg_peek_out && !reg_rd_out) // [R9]
    else $error("no-action command touched registers");
  a_std_write: assert property (byte_end && s.state == ST_WDATA |=>
      reg_wr_out && reg_wr_data_out == $past(s.shift_in) && s.state == ST_DONE) // [R10]
    else $error("standard write not stored once");
  a_done_quiet: assert property (byte_end && s.state == ST_DONE |=> !reg_wr_out) // [R10]
    else $error("extra byte written after standard write");
  a_burst_write: assert property (byte_end && s.state == ST_BURST |=>
      reg_wr_out && s.state == ST_BURST && reg_addr_out == $past(s.addr)) // [R11]
    else $error("burst byte not written to same address");
  a_readback: assert property (reg_wr_out |=>
      reg_peek_out && !reg_rd_out && reg_addr_out == $past(reg_addr_out)) // [R12] [R13]
    else $error("write not followed by side-effect-free read-back");
endmodule // serial_host_port
`default_nettype wire

// ---- serial_host_port_pkg.sv ----
// Notes on behaviour
// R1: port is the register path when upper select is high and lower select low.
// R2: chip select falling starts the port; rising resets it, dropping partial bytes.
// R3: each input bit is taken after a rising serial clock edge.
// R4: each output bit is driven after a falling serial clock edge.
// R5: eight clocks per cycle; parallel transfer after the eighth falling edge.
// R6: both data lines carry each byte most significant bit first.
// R7: command byte holds command in top two bits; previous read data shifts out.
// R8: read command returns addressed register during the following cycle.
// R9: no-action command only repeats previous read data, clearing no flags.
// R10: standard write is command byte plus one data byte, stored at address.
// R11: burst write stores every later data byte at one address until deselect.
// R12: after any write the written register is read back and shifted out next.
// R13: that read-back clears no clear-on-read flags.
// R14: read-back after a transmit FIFO write is undefined; host ignores it.
// R15: host holds select low through each cycle and makes all serial clocks.
`default_nettype none
package serial_host_port_pkg;
  // ****************************************
  // pin synchroniser layout
  // ****************************************
  localparam int          SYNC_W     = 5;
  localparam int          IDX_CS_N   = 0;
  localparam int          IDX_SK     = 1;
  localparam int          IDX_SI     = 2;
  localparam int          IDX_UPPER  = 3;
  localparam int          IDX_LOWER  = 4;
  localparam logic [4:0]  SYNC_RESET = 5'h01;
  // ****************************************
  // byte format
  // ****************************************
  localparam int          DATA_W     = 8;
  localparam int          ADDR_W     = 6;
  localparam logic [3:0]  CNT_ZERO   = 4'h0;
  localparam logic [3:0]  CNT_ONE    = 4'h1;
  localparam logic [3:0]  BITS_PER_CYCLE = 4'h8;
  localparam logic [1:0]  CMD_READ   = 2'h0;
  localparam logic [1:0]  CMD_NOP    = 2'h1;
  localparam logic [1:0]  CMD_WRITE  = 2'h2;
  localparam logic [1:0]  CMD_BURST  = 2'h3;
  localparam logic [7:0]  RDATA_RESET = 8'h00;
  localparam logic [5:0]  ADDR_RESET  = 6'h00;

  typedef enum logic [3:0] {
    ST_CMD   = 4'h1,
    ST_WDATA = 4'h2,
    ST_BURST = 4'h4,
    ST_DONE  = 4'h8
  } port_state_e;
endpackage
`default_nettype wire

// ---- link_if.sv ----
`default_nettype none
interface link_if;
  logic cs_active;
  logic cs_fall;
  logic cs_rise;
  logic sk_rise;
  logic sk_fall;
  logic si;
  logic sel;
  modport prod (output cs_active, cs_fall, cs_rise, sk_rise, sk_fall, si, sel);
  modport cons (input  cs_active, cs_fall, cs_rise, sk_rise, sk_fall, si, sel);
endinterface
`default_nettype wire

// ---- pin_sync.sv ----
`default_nettype none
module pin_sync
  import serial_host_port_pkg::*;
(
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic cs_n_in,
  input  wire logic serial_clock_in,
  input  wire logic serial_data_in,
  input  wire logic iface_select_upper_pin_in,
  input  wire logic iface_select_lower_pin_in,
  link_if.prod      link
);
  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] level;
    logic              prev_cs_n;
    logic              prev_sk;
  } sync_s;

  sync_s s;
  sync_s next_s;

  always_comb begin
    next_s                   = s;
    next_s.meta[IDX_CS_N]    = cs_n_in;
    next_s.meta[IDX_SK]      = serial_clock_in;
    next_s.meta[IDX_SI]      = serial_data_in;
    next_s.meta[IDX_UPPER]   = iface_select_upper_pin_in;
    next_s.meta[IDX_LOWER]   = iface_select_lower_pin_in;
    next_s.level             = s.meta;
    next_s.prev_cs_n         = s.level[IDX_CS_N];
    next_s.prev_sk           = s.level[IDX_SK];
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= '{meta: SYNC_RESET, level: SYNC_RESET, prev_cs_n: 1'b1, prev_sk: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  // edges only from the second stage on, never the metastable first
  assign link.cs_active = ~s.level[IDX_CS_N];
  assign link.cs_fall   = s.prev_cs_n & ~s.level[IDX_CS_N];
  assign link.cs_rise   = ~s.prev_cs_n & s.level[IDX_CS_N];
  assign link.sk_rise   = ~s.prev_sk & s.level[IDX_SK];
  assign link.sk_fall   = s.prev_sk & ~s.level[IDX_SK];
  assign link.si        = s.level[IDX_SI];
  assign link.sel       = s.level[IDX_UPPER] & ~s.level[IDX_LOWER]; // [R1]
endmodule // pin_sync
`default_nettype wire

// ---- host_model.sv ----
`default_nettype none
module host_model (
  input  wire logic mclk_in,
  input  wire logic so_in,
  output var  logic cs_n_out,
  output var  logic sk_out,
  output var  logic si_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_out = 1'b1;
    sk_out   = 1'b0;
    si_out   = 1'b0;
  end
  task automatic idle(input int n);
    repeat (n) @(negedge mclk_in);
  endtask
  task automatic select(input logic lvl);
    idle(1);
    cs_n_out = lvl;
    idle(8);
  endtask
  // *****************************
  // one byte, 320 ns serial clock
  // *****************************
  task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--) begin
      si_out = tx[i];
      idle(4);
      sk_out = 1'b1;
      idle(3);
      rx[i]  = so_in; // late in the high phase, well after the shift has settled
      idle(1);
      sk_out = 1'b0;
    end
    si_out = ~si_out; // released line must not keep a stale bit
    idle(8);
  endtask
endmodule // host_model
`default_nettype wire

// ---- testbench.sv ----
`default_nettype none
module testbench
  import serial_host_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              mclk, rst_n, cs_n, sk, si, upper, lower, so, oe_n, wr, rd, peek;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [7:0]        regs [64];
  logic [7:0]        gold [64];
  logic [7:0]        prev, rx, a, d;
  int                n_errors, n_tests, seed, n_wr, n_rd, n_pk;
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  host_model u_host (.mclk_in(mclk), .so_in(so), .cs_n_out(cs_n), .sk_out(sk), .si_out(si));
  serial_host_port u_serial_host_port (.mclk_in(mclk), .rst_n_in(rst_n), .cs_n_in(cs_n),
    .serial_clock_in(sk), .serial_data_in(si), .iface_select_upper_pin_in(upper),
    .iface_select_lower_pin_in(lower), .serial_data_out(so), .serial_data_oe_n_out(oe_n),
    .reg_addr_out(addr), .reg_wr_out(wr), .reg_wr_data_out(wdata), .reg_rd_out(rd),
    .reg_peek_out(peek), .reg_rd_data_in(regs[addr]));
  always @(posedge mclk) begin
    if (wr === 1'b1) begin
      regs[addr] <= wdata;
    end
    n_wr += (wr === 1'b1);
    n_rd += (rd === 1'b1);
    n_pk += (peek === 1'b1);
  end
  function automatic logic [7:0] cmd(input logic [1:0] c, input logic [7:0] ad);
    return {c, ad[5:0]};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic xb(input logic [7:0] tx, input logic [7:0] exp);
    u_host.shift(tx, 8, rx);
    check(rx, exp);
  endtask
  task automatic counts(input int w, input int r, input int p);
    check(8'(n_wr), 8'(w));
    check(8'(n_rd), 8'(r));
    check(8'(n_pk), 8'(p));
    n_wr = 0;
    n_rd = 0;
    n_pk = 0;
  endtask
  task automatic complete_run;
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    complete_run();
  end
  // *****************************
  // main sequence
  // *****************************
  initial begin
    seed = 32'h57CF;
    {n_errors, n_tests, n_wr, n_rd, n_pk} = '0;
    {rst_n, upper, lower} = 3'h2;
    for (int i = 0; i < 64; i++) begin
      regs[i] = 8'($random(seed));
      gold[i] = regs[i];
    end
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    prev  = RDATA_RESET;
    counts(0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      a = 8'($random(seed)) & 8'h3F;
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'($random(seed));
      u_host.select(1'b0);
      check({7'h00, oe_n}, 8'h00);
      xb(cmd(CMD_WRITE, a), prev);
      xb(d, prev);
      xb(~d, d);
      u_host.select(1'b1);
      counts(1, 0, 1);
      gold[a] = d;
      u_host.select(1'b0);
      xb(cmd(CMD_READ, a), d);
      xb(cmd(CMD_READ, a ^ 8'h01), gold[a]);
      xb(cmd(CMD_NOP, 8'h00), gold[a ^ 8'h01]);
      xb(cmd(CMD_NOP, 8'h00), gold[a ^ 8'h01]);
      u_host.select(1'b1);
      counts(0, 2, 0);
      prev = gold[a ^ 8'h01];
    end
    $display("test write_read done");
    u_host.select(1'b0);
    xb(cmd(CMD_BURST, 8'h15), prev);
    xb(8'h3C, prev);
    xb(8'hC3, 8'h3C);
    xb(8'h5A, 8'hC3);
    xb(cmd(CMD_NOP, 8'h00), 8'h5A);
    u_host.select(1'b1);
    // a burst takes every byte up to deselect, so the last one is data too
    counts(4, 0, 4);
    gold[8'h15] = 8'h40;
    prev = 8'h40;
    $display("test burst done");
    u_host.select(1'b0);
    xb(cmd(CMD_WRITE, 8'h15), prev);
    u_host.shift(8'h81, 4, rx);
    u_host.select(1'b1);
    counts(0, 0, 0);
    u_host.select(1'b0);
    xb(cmd(CMD_NOP, 8'h00), prev);
    u_host.select(1'b1);
    $display("test abort done");
    rst_n = 1'b0;
    u_host.idle(3);
    rst_n = 1'b1;
    u_host.idle(2);
    check({7'h00, oe_n}, 8'h01);
    u_host.select(1'b0);
    xb(cmd(CMD_NOP, 8'h00), RDATA_RESET);
    u_host.select(1'b1);
    counts(0, 0, 0);
    prev = RDATA_RESET;
    $display("test reset done");
    for (int m = 0; m < 3; m++) begin
      {upper, lower} = 2'(m) ^ 2'h1;
      u_host.idle(4);
      u_host.select(1'b0);
      check({7'h00, oe_n}, 8'h01);
      u_host.shift(cmd(CMD_WRITE, 8'h15), 8, rx);
      u_host.shift(8'h99, 8, rx);
      u_host.select(1'b1);
      counts(0, 0, 0);
    end
    {upper, lower} = 2'h2;
    u_host.idle(4);
    u_host.select(1'b0);
    xb(cmd(CMD_READ, 8'h15), prev);
    xb(cmd(CMD_NOP, 8'h00), gold[8'h15]);
    u_host.select(1'b1);
    $display("test deselect done");
    complete_run();
  end
endmodule // testbench
`default_nettype wire
